//--- shared/otgpc_pkg.sv
// otg port control register bank: addresses, field positions, reset values, types
// assumes a 16-bit plain register port and one 100 MHz clock
package otgpc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // address map
    localparam logic [15:0] OTGPC_ADDR_CTRL = 16'hc098;
    localparam logic [15:0] OTGPC_ADDR_EVT  = 16'hc09a;
    localparam logic [15:0] OTGPC_ADDR_MASK = 16'hc09c;

    ////////////////////////////////////////////////////////////////////////////
    // control/status word field positions
    localparam int OTGPC_BIT_VBUS_PU  = 13;
    localparam int OTGPC_BIT_RX_PD    = 12;
    localparam int OTGPC_BIT_CPUMP    = 11;
    localparam int OTGPC_BIT_VBUS_DIS = 10;
    localparam int OTGPC_BIT_DP_PU    = 9;
    localparam int OTGPC_BIT_DM_PU    = 8;
    localparam int OTGPC_BIT_DP_PD    = 7;
    localparam int OTGPC_BIT_DM_PD    = 6;
    localparam int OTGPC_BIT_VBUS_LVL = 2;
    localparam int OTGPC_BIT_ID       = 1;
    localparam int OTGPC_BIT_VALID    = 0;

    // event and mask registers: bit 2 vbus level change, 1 id change, 0 valid change
    localparam int OTGPC_EVT_W = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values
    localparam logic [15:0]            OTGPC_CTRL_RST = 16'h0000;
    localparam logic [OTGPC_EVT_W-1:0] OTGPC_EVT_RST  = 3'h0;
    localparam logic [OTGPC_EVT_W-1:0] OTGPC_MASK_RST = 3'h0;
    localparam logic [15:0]            OTGPC_RD_NONE  = 16'h0000;

    ////////////////////////////////////////////////////////////////////////////
    // types
    typedef struct packed {
        logic vbusPullUp;
        logic rxPowerDown;
        logic chargePump;
        logic vbusDischarge;
        logic dpPullUp;
        logic dmPullUp;
        logic dpPullDown;
        logic dmPullDown;
    } otgpc_ctrl_t;

    typedef struct packed {
        logic vbusLevel;
        logic idFloat;
        logic vbusValid;
    } otgpc_stat_t;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wrData;
        logic        wrStrobe;
        logic        rdStrobe;
    } otgpc_bus_t;

    localparam otgpc_ctrl_t OTGPC_CTRL_OFF = otgpc_ctrl_t'(8'h00);

endpackage

//--- logic/otgpc_port_control.sv
// otg port control and status register with change interrupt
// assumes inputs synchronous to clock except the three analog status levels
`timescale 1ns/1ps
module otgpc_port_control (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  srst,
    // register port
    input  wire otgpc_pkg::otgpc_bus_t bus,
    output      logic [15:0]           rdData,
    // analog port status levels
    input  wire otgpc_pkg::otgpc_stat_t portStat,
    // analog port controls
    output      otgpc_pkg::otgpc_ctrl_t portCtrl,
    // interrupt
    output      logic                  irq
);

    ////////////////////////////////////////////////////////////////////////////
    // packing of the control/status word

    function automatic logic [15:0] packWord(input otgpc_pkg::otgpc_ctrl_t c,
                                             input otgpc_pkg::otgpc_stat_t s);
        logic [15:0] w;
        w = 16'h0000;
        w[otgpc_pkg::OTGPC_BIT_VBUS_PU]  = c.vbusPullUp;
        w[otgpc_pkg::OTGPC_BIT_RX_PD]    = c.rxPowerDown;
        w[otgpc_pkg::OTGPC_BIT_CPUMP]    = c.chargePump;
        w[otgpc_pkg::OTGPC_BIT_VBUS_DIS] = c.vbusDischarge;
        w[otgpc_pkg::OTGPC_BIT_DP_PU]    = c.dpPullUp;
        w[otgpc_pkg::OTGPC_BIT_DM_PU]    = c.dmPullUp;
        w[otgpc_pkg::OTGPC_BIT_DP_PD]    = c.dpPullDown;
        w[otgpc_pkg::OTGPC_BIT_DM_PD]    = c.dmPullDown;
        w[otgpc_pkg::OTGPC_BIT_VBUS_LVL] = s.vbusLevel;
        w[otgpc_pkg::OTGPC_BIT_ID]       = s.idFloat;
        w[otgpc_pkg::OTGPC_BIT_VALID]    = s.vbusValid;
        return w;
    endfunction

    function automatic otgpc_pkg::otgpc_ctrl_t unpackCtrl(input logic [15:0] w);
        otgpc_pkg::otgpc_ctrl_t c;
        c.vbusPullUp    = w[otgpc_pkg::OTGPC_BIT_VBUS_PU];
        c.rxPowerDown   = w[otgpc_pkg::OTGPC_BIT_RX_PD];
        c.chargePump    = w[otgpc_pkg::OTGPC_BIT_CPUMP];
        c.vbusDischarge = w[otgpc_pkg::OTGPC_BIT_VBUS_DIS];
        c.dpPullUp      = w[otgpc_pkg::OTGPC_BIT_DP_PU];
        c.dmPullUp      = w[otgpc_pkg::OTGPC_BIT_DM_PU];
        c.dpPullDown    = w[otgpc_pkg::OTGPC_BIT_DP_PD];
        c.dmPullDown    = w[otgpc_pkg::OTGPC_BIT_DM_PD];
        return c;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // declarations

    otgpc_pkg::otgpc_ctrl_t            ctrl_r;
    otgpc_pkg::otgpc_stat_t            syncA_r;
    otgpc_pkg::otgpc_stat_t            syncB_r;
    otgpc_pkg::otgpc_stat_t            statPrev_r;
    logic                              statPrimed_r;
    logic [otgpc_pkg::OTGPC_EVT_W-1:0] evt_r;
    logic [otgpc_pkg::OTGPC_EVT_W-1:0] evt_nxt;
    logic [otgpc_pkg::OTGPC_EVT_W-1:0] mask_r;
    logic [otgpc_pkg::OTGPC_EVT_W-1:0] change;
    logic [15:0]                       rdData_r;
    logic [15:0]                       rdData_nxt;
    logic                              irq_r;
    logic                              wrCtrl;
    logic                              wrEvt;
    logic                              wrMask;

    assign wrCtrl = bus.wrStrobe && (bus.addr == otgpc_pkg::OTGPC_ADDR_CTRL);
    assign wrEvt  = bus.wrStrobe && (bus.addr == otgpc_pkg::OTGPC_ADDR_EVT);
    assign wrMask = bus.wrStrobe && (bus.addr == otgpc_pkg::OTGPC_ADDR_MASK);

    ////////////////////////////////////////////////////////////////////////////
    // control bits; status positions of a write are dropped

    always_ff @(posedge clock) begin
        if (srst) begin
            ctrl_r <= otgpc_pkg::OTGPC_CTRL_OFF;
        end else if (wrCtrl) begin
            ctrl_r <= unpackCtrl(bus.wrData);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // status synchroniser; first stage feeds only the second

    always_ff @(posedge clock) begin
        if (srst) begin
            syncA_r <= otgpc_pkg::otgpc_stat_t'(3'h0);
            syncB_r <= otgpc_pkg::otgpc_stat_t'(3'h0);
        end else begin
            syncA_r <= portStat;
            syncB_r <= syncA_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // change detection; primed flag masks only the first cycle after reset, so a level high during reset still raises its event

    always_ff @(posedge clock) begin
        if (srst) begin
            statPrev_r   <= otgpc_pkg::otgpc_stat_t'(3'h0);
            statPrimed_r <= 1'b0;
        end else begin
            statPrev_r   <= syncB_r;
            statPrimed_r <= 1'b1;
        end
    end

    assign change = statPrimed_r ? (syncB_r ^ statPrev_r) : 3'h0;

    ////////////////////////////////////////////////////////////////////////////
    // sticky events, write one to clear; a new change wins over the clear

    always_comb begin
        evt_nxt = evt_r;
        if (wrEvt) begin
            evt_nxt = evt_nxt & ~bus.wrData[otgpc_pkg::OTGPC_EVT_W-1:0];
        end
        evt_nxt = evt_nxt | change;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            evt_r <= otgpc_pkg::OTGPC_EVT_RST;
        end else begin
            evt_r <= evt_nxt;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            mask_r <= otgpc_pkg::OTGPC_MASK_RST;
        end else if (wrMask) begin
            mask_r <= bus.wrData[otgpc_pkg::OTGPC_EVT_W-1:0];
        end
    end

    // registered from next state so irq follows the event in the same cycle
    always_ff @(posedge clock) begin
        if (srst) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= |(evt_nxt & (wrMask ? bus.wrData[otgpc_pkg::OTGPC_EVT_W-1:0]
                                         : mask_r));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read data; zero outside a read so stale words never linger

    always_comb begin
        rdData_nxt = otgpc_pkg::OTGPC_RD_NONE;
        if (bus.rdStrobe) begin
            case (bus.addr)
                otgpc_pkg::OTGPC_ADDR_CTRL: rdData_nxt = packWord(ctrl_r, syncB_r);
                otgpc_pkg::OTGPC_ADDR_EVT:  rdData_nxt = {13'h0000, evt_r};
                otgpc_pkg::OTGPC_ADDR_MASK: rdData_nxt = {13'h0000, mask_r};
                default:                    rdData_nxt = otgpc_pkg::OTGPC_RD_NONE;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            rdData_r <= otgpc_pkg::OTGPC_RD_NONE;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rdData   = rdData_r;
    assign portCtrl = ctrl_r;
    assign irq      = irq_r;

endmodule // otgpc_port_control

//--- testbench/otgpc_port_control_monitor.sv
// port checker for the otg_port_control_status
// assumes one clock and synchronous srst; bound onto the register block
`timescale 1ns/1ps
module otgpc_port_control_monitor (
    // clock and reset
    input wire logic                   clock,
    input wire logic                   srst,
    // register port
    input wire otgpc_pkg::otgpc_bus_t  bus,
    input wire logic [15:0]            rdData,
    // port side
    input wire otgpc_pkg::otgpc_stat_t portStat,
    input wire otgpc_pkg::otgpc_ctrl_t portCtrl,
    input wire logic                   irq
);
    logic       wrC, rdC, rdX, wrM;
    logic [7:0] wBits;
    assign wrC   = bus.wrStrobe && bus.addr == 16'hc098;
    assign rdC   = bus.rdStrobe && bus.addr == 16'hc098;
    assign rdX   = bus.rdStrobe && !(bus.addr inside {16'hc098, 16'hc09a, 16'hc09c});
    assign wrM   = bus.wrStrobe && bus.addr == 16'hc09c && bus.wrData[2:0] == 3'h0;
    assign wBits = bus.wrData[13:6];
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    ////////////////////////////////////////////////////////////////////////////
    AST_WR_CTRL: assert property (wrC |=> portCtrl == $past(wBits))
        else $error("control word not taken");
    AST_CTRL_HOLD: assert property (!wrC |=> $stable(portCtrl))
        else $error("control moved without write");
    AST_RD_CTRL: assert property (rdC |=> rdData[15:3] == {2'h0, $past(portCtrl), 3'h0})
        else $error("control readback wrong");
    // pins held three samples so both sync stages carry them
    AST_RD_STAT: assert property ((!srst && $stable(portStat))[*3] ##0 rdC
        |=> rdData[2:0] == $past(portStat, 2)) else $error("status readback wrong");
    AST_RD_UNMAP: assert property (rdX |=> rdData == 16'h0000)
        else $error("unmapped read not zero");
    AST_RD_IDLE: assert property (!bus.rdStrobe |=> rdData == 16'h0000)
        else $error("read data outside read slot");
    AST_IRQ_OFF: assert property (wrM |=> !irq)
        else $error("irq high with mask clear");
    AST_RESET: assert property (disable iff (1'h0) srst |=> portCtrl == 8'h00 && !irq)
        else $error("reset state wrong");
endmodule // otgpc_port_control_monitor

bind otgpc_port_control otgpc_port_control_monitor mon (.clock, .srst, .bus, .rdData,
    .portStat, .portCtrl, .irq);

//--- testbench/otgpc_analog_model.sv
// analog port stand-in: pump, pull-up, id pin, vbus comparator
// assumes control levels from the register and an id state from the bench
`timescale 1ns/1ps
module otgpc_analog_model #(
    parameter int SETTLE = 20
) (
    input  wire logic                   clock,
    input  wire otgpc_pkg::otgpc_ctrl_t portCtrl,
    input  wire logic                   idGrounded,
    output      otgpc_pkg::otgpc_stat_t portStat
);
    int rise = 0;
    // valid lags the pump, so early reads see it low
    always @(posedge clock) rise <= portCtrl.chargePump ? (rise < SETTLE ? rise + 1 : rise) : 0;
    always_comb begin
        portStat.vbusLevel = portCtrl.chargePump | portCtrl.vbusPullUp;
        portStat.idFloat   = !idGrounded;
        portStat.vbusValid = rise == SETTLE;
    end
endmodule // otgpc_analog_model

//--- testbench/otgpc_port_control_test.sv
// self-checking bench for the otg_port_control_status
// assumes the analog model on the port side and a 100 MHz clock
`timescale 1ns/1ps
module otgpc_port_control_test;
    localparam logic [15:0] CTRL = otgpc_pkg::OTGPC_ADDR_CTRL;
    localparam logic [15:0] EVT  = otgpc_pkg::OTGPC_ADDR_EVT;
    localparam logic [15:0] MASK = otgpc_pkg::OTGPC_ADDR_MASK;
    logic                   clock = 1'h0;
    logic                   srst  = 1'h1;
    logic                   idGnd = 1'h0;
    otgpc_pkg::otgpc_bus_t  bus   = '0;
    logic [15:0]            rdData;
    otgpc_pkg::otgpc_stat_t portStat;
    otgpc_pkg::otgpc_ctrl_t portCtrl;
    logic                   irq;
    int                     num_errors = 0;
    int                     checked = 0;
    int                     cycles = 0;
    otgpc_port_control DUT (.clock, .srst, .bus, .rdData, .portStat, .portCtrl, .irq);
    otgpc_analog_model #(.SETTLE(20)) model (.clock, .portCtrl, .idGrounded(idGnd), .portStat);
    initial forever #5 clock = ~clock;
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            num_errors++;
            stop_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(logic [15:0] a, logic [15:0] d);
        @(posedge clock);
        bus <= '{a, d, 1'h1, 1'h0};
        @(posedge clock);
        bus.wrStrobe <= 1'h0;
    endtask
    task automatic rdc(string nm, logic [15:0] a, logic [15:0] exp);
        @(posedge clock);
        bus <= '{a, 16'h0000, 1'h0, 1'h1};
        @(posedge clock);
        bus.rdStrobe <= 1'h0;
        #1 check(nm, rdData, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic scn_reset();
        repeat (3) @(posedge clock);
        #1 check("ctrl out", {8'h00, portCtrl}, 16'h0000);
        rdc("ctrl", CTRL, 16'h0002);
        rdc("evt", EVT, 16'h0002);
    endtask
    task automatic scn_bits();
        logic cp, lvl;
        for (int i = 6; i < 14; i++) begin
            cp = (i == 11);
            lvl = cp || i == 13;
            // reserved and status bits written as ones must not stick
            wr(CTRL, 16'hc03f | (16'h0001 << i));
            #1 check("ctrl out", {8'h00, portCtrl}, 16'h0001 << (i - 6));
            repeat (30) @(posedge clock);
            rdc("ctrl", CTRL, (16'h0001 << i) | {13'h0000, lvl, 1'h1, cp});
        end
        wr(CTRL, 16'h0000);
        repeat (30) @(posedge clock);
    endtask
    task automatic scn_unmapped();
        wr(16'hc096, 16'h3fc0);
        #1 check("ctrl out", {8'h00, portCtrl}, 16'h0000);
        rdc("unmapped", 16'hc096, 16'h0000);
    endtask
    task automatic scn_irq();
        wr(EVT, 16'h0007);
        wr(MASK, 16'h0001);
        wr(CTRL, 16'h0800);
        repeat (30) @(posedge clock);
        #1 check("irq", {15'h0000, irq}, 16'h0001);
        rdc("evt", EVT, 16'h0005);
        wr(MASK, 16'h0000);
        #1 check("irq", {15'h0000, irq}, 16'h0000);
        wr(MASK, 16'h0001);
        #1 check("irq", {15'h0000, irq}, 16'h0001);
        rdc("mask", MASK, 16'h0001);
        wr(EVT, 16'h0001);
        repeat (2) @(posedge clock);
        #1 check("irq", {15'h0000, irq}, 16'h0000);
        @(posedge clock) idGnd <= 1'h1;
        repeat (5) @(posedge clock);
        rdc("evt", EVT, 16'h0006);
        rdc("ctrl", CTRL, 16'h0805);
        check("irq", {15'h0000, irq}, 16'h0000);
    endtask
    initial begin
        repeat (6) @(posedge clock);
        srst <= 1'h0;
        scn_reset();
        scn_bits();
        scn_unmapped();
        scn_irq();
        stop_test();
    end
endmodule // otgpc_port_control_test
